/* File: bls_map.svh */
/*
  Constants for the bus lane steer and split block: size and type
  codes, fixed acknowledge addresses, lane masks and counts.
  Assumes it is included by the package and the design modules.
*/
// What the document requires of this block
// R1: No narrow-port cycles; slaves take full width.
// R2: Contiguous memory regions are 32-bit ports.
// R3: Vector ports sit on low 8/16 lines.
// R4: Size codes: byte 01, word 10, long 00, line 11.
// R5: Byte lane chosen by offset, D31-D24 first.
// R6: Word uses upper lanes at 0, lower at 2.
// R7: Long word and line use all lanes.
// R8: Unselected lanes ignored on read, undefined on write.
// R9: Address is long-word base plus offset; size held.
// R10: Burst-inhibited line keeps first low address bits.
// R11: Transfer type codes per access class.
// R12: Line entry defined only for push/normal line read.
// R13: Lock during locked sequences; lock end on last (code also marks the first beat of a burst-inhibited line).
// R14: Page attribute and inhibit from page fields.
// R15: Misaligned: odd word, long not divisible by four.
// R16: Odd instruction fetch raises address error.
// R17: Split noncachable misaligned; cachable passes whole.
// R18: Long at one: byte, word, byte next long.
// R19: Cycle counts by size and offset.
// R20: Any operand byte routes to any lane.
// R21: Everything sampled and driven on rising edge.
`ifndef BLS_MAP_SVH
`define BLS_MAP_SVH

`define BLS_SIZ_BYTE 2'h1
`define BLS_SIZ_WORD 2'h2
`define BLS_SIZ_LONG 2'h0
`define BLS_SIZ_LINE 2'h3

`define BLS_TT_NORMAL 2'h0
`define BLS_TT_LINE_MOVE 2'h1
`define BLS_TT_ALTERNATE 2'h2
`define BLS_TT_ACK 2'h3

`define BLS_TM_ZERO 3'h0
`define BLS_ADDR_INT_ACK 32'hFFFFFFFF
`define BLS_ADDR_BKPT_ACK 32'h00000000

`define BLS_LANES_ALL 4'hF
`define BLS_LANES_BYTE0 4'h8
`define BLS_LANES_WORD_HI 4'hC
`define BLS_LANES_WORD_LO 4'h3

`define BLS_RETRY_BEATS 2'h3

`endif

/* File: bls_pkg.sv */
/*
  Types for the bus lane steer and split block.
  Assumes bls_map.svh is reachable by bare name.
*/
`include "bls_map.svh"

package bls_pkg;

  // Access classes that shape the bus attribute encodings
  typedef enum logic [2:0] {
    BLS_PUSH = 3'h0,
    BLS_NORMAL = 3'h1,
    BLS_TABLE = 3'h2,
    BLS_LINE_MOVE = 3'h3,
    BLS_ALTERNATE = 3'h4,
    BLS_INT_ACK = 3'h5,
    BLS_BKPT_ACK = 3'h6
  } bls_class_t;

  // Gray coded along idle, issue, wait
  typedef enum logic [1:0] {
    BLS_IDLE = 2'h0,
    BLS_ISSUE = 2'h1,
    BLS_WAIT = 2'h3
  } bls_state_t;

  // One operand access from the memory unit
  typedef struct packed {
    bls_class_t acc_class;
    logic [31:0] address;
    logic [1:0] transfer_size;
    logic write;
    logic fetch;
    logic cachable;
    logic [31:0] wdata;
    logic [2:0] transfer_modifier;
    logic [1:0] cache_line_entry;
    logic [1:0] user_page_bits;
    logic cache_mode_field;
    logic lock;
    logic lock_end;
  } bls_req_t;

  // Bus cycle as driven onto the pins
  typedef struct packed {
    logic valid;
    logic [31:0] address;
    logic [1:0] transfer_size;
    logic [1:0] transfer_type;
    logic [2:0] transfer_modifier;
    logic [1:0] cache_line_entry;
    logic [1:0] user_page_attribute;
    logic cache_inhibit_out;
    logic lock;
    logic locked_sequence_end;
    logic write;
    logic [3:0] active_lane;
    logic [31:0] wdata;
  } bls_bus_t;

  // Completion back to the memory unit
  typedef struct packed {
    logic valid;
    logic addr_error;
    logic [31:0] rdata;
  } bls_rsp_t;

  // Whole state of the top module
  typedef struct packed {
    bls_state_t state;
    bls_req_t req;
    logic [31:0] addr;
    logic [31:0] operand;
    logic [31:0] acc;
    logic [2:0] rem;
    logic [2:0] plen;
    logic [1:0] kidx;
    logic retry;
    logic [1:0] beats;
    logic ready;
    bls_bus_t bus;
    bls_rsp_t rsp;
  } bls_top_t;

endpackage : bls_pkg

/* File: bls_lane_steer.sv */
/*
  Combinational byte router between a left-justified operand and
  the four lanes of the 32-bit data bus, both directions.
  Assumes lane 0 is D31-D24 and operand byte 0 is its top byte.
*/
`timescale 1ns/1ps

module bls_lane_steer (
  input wire logic [31:0] i_operand,
  input wire logic [31:0] i_acc,
  input wire logic [31:0] i_bus_rdata,
  input wire logic [1:0] i_first_byte,
  input wire logic [1:0] i_offset,
  input wire logic [3:0] i_lanes,
  output logic [31:0] o_bus_wdata,
  output logic [31:0] o_acc
);

  // Each lane picks operand byte first_byte + lane - offset
  for (genvar lane = 0; lane < 4; lane++)
  begin : g_lane
    logic [1:0] k;
    logic on;
    assign k = 2'(i_first_byte + 2'(lane) - i_offset); // R20
    assign on = i_lanes[3 - lane];
    // Unused lanes drive zero; slaves must not select them
    assign o_bus_wdata[31 - 8*lane -: 8] =
      on ? i_operand[31 - 8*k -: 8] : 8'h00; // R8
  end

  // Gather read lanes back into operand order; other lanes ignored
  always_comb
  begin
    o_acc = i_acc;
    for (int lane = 0; lane < 4; lane++)
    begin
      if (i_lanes[3 - lane])
      begin
        o_acc[31 - 8*(2'(i_first_byte + 2'(lane) - i_offset)) -: 8] =
          i_bus_rdata[31 - 8*lane -: 8]; // R8
      end
    end
  end

endmodule : bls_lane_steer

/* File: bls_bus_lane_steer_and_split.sv */
/*
  Processor-side bus data path: splits misaligned noncachable
  operands into aligned cycles, steers bytes to lanes and drives
  the per-class address and attribute encodings.
  Assumes the cycle handshake lives outside: i_cycle_done ends the
  cycle shown by o_bus.valid; burst beats beyond the first are not
  handled here, only the burst-inhibit continuation.
  Every output is a register field; no pin is fed through logic.
*/
`timescale 1ns/1ps
`include "bls_map.svh"

module bls_bus_lane_steer_and_split (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_req_valid,
  input wire bls_pkg::bls_req_t i_req,
  input wire logic i_cycle_done,
  input wire logic i_burst_inhibit,
  input wire logic [31:0] i_bus_rdata,
  output logic o_req_ready,
  output bls_pkg::bls_bus_t o_bus,
  output bls_pkg::bls_rsp_t o_rsp
);

  // Whole block state and its next value
  bls_pkg::bls_top_t s_reg;
  bls_pkg::bls_top_t s_next;
  // Data passing through the lane router, both directions
  logic [31:0] steer_wdata;
  logic [31:0] steer_acc;
  logic [3:0] cur_lanes;
  logic [1:0] cur_size;
  logic [2:0] cur_len;
  // Router offset; a line beat is never rotated
  logic [1:0] steer_off;

  // Lane mask from size code and byte offset
  function automatic logic [3:0] lane_mask(
    input logic [1:0] size,
    input logic [1:0] off
  );
    logic [3:0] m;
    // Long and line keep every lane; narrower sizes pick by offset
    m = `BLS_LANES_ALL; // R7
    if (size == `BLS_SIZ_BYTE)
    begin
      m = `BLS_LANES_BYTE0 >> off; // R5
    end
    else if (size == `BLS_SIZ_WORD)
    begin
      m = off[1] ? `BLS_LANES_WORD_LO : `BLS_LANES_WORD_HI; // R6
    end
    return m;
  endfunction : lane_mask

  // Operand length in bytes for a request size
  function automatic logic [2:0] size_bytes(input logic [1:0] size);
    logic [2:0] n;
    // Long and line both move four bytes per cycle
    n = 3'h4;
    if (size == `BLS_SIZ_BYTE)
    begin
      n = 3'h1;
    end
    else if (size == `BLS_SIZ_WORD)
    begin
      n = 3'h2;
    end
    return n;
  endfunction : size_bytes

  // Largest aligned piece that fits at this offset
  function automatic logic [1:0] piece_size(
    input logic [1:0] off,
    input logic [2:0] rem
  );
    logic [1:0] z;
    // Long needs offset 0, word an even offset; otherwise a byte
    z = `BLS_SIZ_BYTE; // R15
    if (rem >= 3'h4 && off == 2'h0)
    begin
      z = `BLS_SIZ_LONG;
    end
    else if (rem >= 3'h2 && !off[0])
    begin
      z = `BLS_SIZ_WORD;
    end
    return z;
  endfunction : piece_size

  // Size and lanes of the cycle about to be issued
  always_comb
  begin
    cur_size = s_reg.req.transfer_size;
    if (s_reg.req.transfer_size == `BLS_SIZ_LINE)
    begin
      cur_size = s_reg.retry ? `BLS_SIZ_LONG : `BLS_SIZ_LINE; // R10
    end
    else if (!s_reg.req.cachable)
    begin
      cur_size = piece_size(s_reg.addr[1:0], s_reg.rem); // R17
    end
    // Piece length steps the address and the operand index
    cur_len = size_bytes(cur_size);
    cur_lanes = lane_mask(cur_size, s_reg.addr[1:0]);
    // Line beats are whole long words, handed over as on the bus
    steer_off = s_reg.addr[1:0];
    if (s_reg.req.transfer_size == `BLS_SIZ_LINE)
    begin
      steer_off = 2'h0; // R7
    end
  end

  // Current piece's lanes; during wait they equal the registered mask
  bls_lane_steer u_steer (
    .i_operand(s_reg.operand),
    .i_acc(s_reg.acc),
    .i_bus_rdata(i_bus_rdata),
    .i_first_byte(s_reg.kidx),
    .i_offset(steer_off),
    .i_lanes(cur_lanes),
    .o_bus_wdata(steer_wdata),
    .o_acc(steer_acc)
  );

  // Next state: idle takes a request, issue drives one cycle,
  // wait merges data and decides whether more pieces follow
  always_comb
  begin
    s_next = s_reg;
    s_next.rsp.valid = 1'b0;
    s_next.rsp.addr_error = 1'b0;
    case (s_reg.state)
      bls_pkg::BLS_IDLE:
      begin
        if (i_req_valid)
        begin
          // Whole request kept; every piece is cut from this copy
          s_next.req = i_req;
          if (i_req.fetch && i_req.address[0])
          begin
            // Odd fetch never reaches the bus
            s_next.rsp.valid = 1'b1; // R16
            s_next.rsp.addr_error = 1'b1; // R16
          end
          else
          begin
            s_next.addr = i_req.address;
            s_next.rem = size_bytes(i_req.transfer_size);
            // Left-justify so operand byte 0 is the top byte
            s_next.operand = i_req.wdata <<
              (6'(8) * 6'(3'h4 - size_bytes(i_req.transfer_size)));
            // Acknowledge cycles go to a fixed address as one byte
            if (i_req.acc_class == bls_pkg::BLS_INT_ACK)
            begin
              s_next.addr = `BLS_ADDR_INT_ACK;
              s_next.req.transfer_size = `BLS_SIZ_BYTE;
              s_next.rem = 3'h1;
            end
            else if (i_req.acc_class == bls_pkg::BLS_BKPT_ACK)
            begin
              s_next.addr = `BLS_ADDR_BKPT_ACK;
              s_next.req.transfer_size = `BLS_SIZ_BYTE;
              s_next.rem = 3'h1;
            end
            // Fresh request: first operand byte, empty gather
            s_next.kidx = 2'h0;
            s_next.acc = 32'h00000000;
            s_next.retry = 1'b0;
            s_next.beats = 2'h0;
            s_next.state = bls_pkg::BLS_ISSUE;
          end
        end
      end
      bls_pkg::BLS_ISSUE:
      begin
        s_next.plen = cur_len;
        s_next.bus.valid = 1'b1;
        s_next.bus.address = s_reg.addr; // R9
        // Size issued is final; a narrow slave gets no second try
        s_next.bus.transfer_size = cur_size; // R1 R4
        s_next.bus.active_lane = cur_lanes;
        // Write lanes registered here so the pins come from flops
        s_next.bus.wdata = steer_wdata; // R8
        s_next.bus.write = s_reg.req.write;
        s_next.bus.transfer_modifier = s_reg.req.transfer_modifier;
        s_next.bus.transfer_type = `BLS_TT_NORMAL; // R11
        s_next.bus.user_page_attribute = 2'h0;
        s_next.bus.cache_inhibit_out = 1'b0;
        s_next.bus.cache_line_entry = 2'h0;
        // Defaults above; each class overrides only what it owns
        case (s_reg.req.acc_class)
          bls_pkg::BLS_PUSH:
          begin
            s_next.bus.transfer_modifier = `BLS_TM_ZERO;
            s_next.bus.cache_line_entry =
              s_reg.req.cache_line_entry; // R12
          end
          bls_pkg::BLS_NORMAL:
          begin
            s_next.bus.user_page_attribute =
              s_reg.req.user_page_bits; // R14
            s_next.bus.cache_inhibit_out =
              s_reg.req.cache_mode_field; // R14
            if (cur_size == `BLS_SIZ_LINE && !s_reg.req.write)
            begin
              s_next.bus.cache_line_entry =
                s_reg.req.cache_line_entry; // R12
            end
          end
          bls_pkg::BLS_LINE_MOVE:
          begin
            s_next.bus.transfer_type = `BLS_TT_LINE_MOVE; // R11
            s_next.bus.user_page_attribute =
              s_reg.req.user_page_bits; // R14
            s_next.bus.cache_inhibit_out =
              s_reg.req.cache_mode_field; // R14
          end
          bls_pkg::BLS_ALTERNATE:
          begin
            s_next.bus.transfer_type = `BLS_TT_ALTERNATE; // R11
            // Alternate space is never cached
            s_next.bus.cache_inhibit_out = 1'b1;
          end
          bls_pkg::BLS_INT_ACK:
          begin
            s_next.bus.transfer_type = `BLS_TT_ACK; // R11
            s_next.bus.write = 1'b0;
          end
          bls_pkg::BLS_BKPT_ACK:
          begin
            s_next.bus.transfer_type = `BLS_TT_ACK; // R11
            s_next.bus.transfer_modifier = `BLS_TM_ZERO;
            s_next.bus.write = 1'b0;
          end
          default:
          begin
            s_next.bus.transfer_type = `BLS_TT_NORMAL; // R11
          end
        endcase
        s_next.bus.lock = s_reg.req.lock; // R13
        // Lock end marks the final cycle of the request, and also the first beat of a burst-inhibited line
        s_next.bus.locked_sequence_end = s_reg.req.lock_end &&
          (s_reg.req.transfer_size == `BLS_SIZ_LINE ?
           (!s_reg.retry || s_reg.beats == `BLS_RETRY_BEATS) :
           (cur_len >= s_reg.rem)); // R13
        s_next.state = bls_pkg::BLS_WAIT;
      end
      bls_pkg::BLS_WAIT:
      begin
        // Size and address stay put until the cycle ends
        if (i_cycle_done) // R9
        begin
          s_next.bus.valid = 1'b0;
          s_next.bus.lock = 1'b0;
          s_next.bus.locked_sequence_end = 1'b0;
          // Gather only the lanes this piece selected
          s_next.acc = steer_acc;
          if (s_reg.req.transfer_size == `BLS_SIZ_LINE)
          begin
            // Each long word of a line read is handed back as it arrives
            s_next.rsp.valid = !s_reg.req.write;
            s_next.rsp.rdata = steer_acc;
            // Burst inhibit counts only on the first beat of a line
            if (!s_reg.retry && i_burst_inhibit)
            begin
              s_next.retry = 1'b1;
              s_next.beats = 2'h1;
              // Step A3:A2 with wrap, keep A1:A0 as first issued
              s_next.addr = {s_reg.addr[31:4],
                             2'(s_reg.addr[3:2] + 2'h1),
                             s_reg.addr[1:0]}; // R10
              s_next.state = bls_pkg::BLS_ISSUE;
            end
            else if (s_reg.retry && s_reg.beats != `BLS_RETRY_BEATS)
            begin
              s_next.beats = 2'(s_reg.beats + 2'h1);
              s_next.addr = {s_reg.addr[31:4],
                             2'(s_reg.addr[3:2] + 2'h1),
                             s_reg.addr[1:0]}; // R10
              s_next.state = bls_pkg::BLS_ISSUE;
            end
            else
            begin
              s_next.rsp.valid = 1'b1;
              s_next.state = bls_pkg::BLS_IDLE;
            end
          end
          else
          begin
            // Advance past the bytes this piece carried
            s_next.rem = 3'(s_reg.rem - s_reg.plen); // R19
            s_next.addr = 32'(s_reg.addr + 32'(s_reg.plen)); // R18
            s_next.kidx = 2'(s_reg.kidx + s_reg.plen[1:0]); // R20
            // Last piece: right-justify the gathered operand bytes
            if (s_reg.plen >= s_reg.rem)
            begin
              s_next.rsp.valid = 1'b1;
              s_next.rsp.rdata = steer_acc >>
                (6'(8) * 6'(3'h4 -
                 size_bytes(s_reg.req.transfer_size)));
              s_next.state = bls_pkg::BLS_IDLE;
            end
            else
            begin
              s_next.state = bls_pkg::BLS_ISSUE;
            end
          end
        end
      end
      default:
      begin
        // Unused state code falls back to idle
        s_next.state = bls_pkg::BLS_IDLE;
      end
    endcase
    s_next.ready = (s_next.state == bls_pkg::BLS_IDLE);
  end

  // Single register stage on the rising edge for all state
  always_ff @(posedge i_clock) // R21
  begin
    // Reset leaves the bus idle and the request port open
    if (i_sys_rst)
    begin
      s_reg <= '0;
      s_reg.state <= bls_pkg::BLS_IDLE;
      s_reg.ready <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Every output is a register field, wired straight to the pins
  always_comb
  begin
    o_bus = s_reg.bus;
    o_rsp = s_reg.rsp;
    o_req_ready = s_reg.ready;
  end

endmodule : bls_bus_lane_steer_and_split

/* File: bls_chk_assertions.sv */
/*
  Port checker for the bus lane steer and split top module.
  Assumes it is bound onto every instance of that top module.
*/
`timescale 1ns/1ps
`include "bls_map.svh"

module bls_chk (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_req_valid,
  input wire bls_pkg::bls_req_t i_req,
  input wire logic i_cycle_done,
  input wire logic i_burst_inhibit,
  input wire logic [31:0] i_bus_rdata,
  input wire logic o_req_ready,
  input wire bls_pkg::bls_bus_t o_bus,
  input wire bls_pkg::bls_rsp_t o_rsp
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  // Request steps: taken, then either bus work or a fetch error
  sequence s_bus_req;
    i_req_valid && o_req_ready && !(i_req.fetch && i_req.address[0]);
  endsequence
  sequence s_odd_fetch;
    i_req_valid && o_req_ready && i_req.fetch && i_req.address[0];
  endsequence
  sequence s_issue;
    (!o_req_ready && !o_bus.valid) ##1 o_bus.valid;
  endsequence

  a_issue_delay: assert property (s_bus_req |=> s_issue)
    else $error("bus cycle not issued two edges after request");
  a_fetch_error: assert property (s_odd_fetch |=>
    o_rsp.valid && o_rsp.addr_error && !o_bus.valid)
    else $error("odd fetch not refused with address error");
  a_hold_attr: assert property (o_bus.valid && !i_cycle_done |=>
    o_bus.valid && $stable(o_bus.address) && $stable(o_bus.transfer_size)
    && $stable(o_bus.transfer_type))
    else $error("bus cycle changed before its end");
  a_gap_cycle: assert property (o_bus.valid && i_cycle_done |=>
    !o_bus.valid)
    else $error("bus cycle kept after done");
  a_byte_lane: assert property (o_bus.valid &&
    o_bus.transfer_size == `BLS_SIZ_BYTE |->
    o_bus.active_lane == (`BLS_LANES_BYTE0 >> o_bus.address[1:0]))
    else $error("byte lane does not follow offset");
  a_word_lane: assert property (o_bus.valid &&
    o_bus.transfer_size == `BLS_SIZ_WORD |-> !o_bus.address[0] &&
    o_bus.active_lane == (o_bus.address[1] ? `BLS_LANES_WORD_LO :
    `BLS_LANES_WORD_HI))
    else $error("word lanes wrong or odd word offset");
  a_wide_lanes: assert property (o_bus.valid &&
    (o_bus.transfer_size == `BLS_SIZ_LONG ||
    o_bus.transfer_size == `BLS_SIZ_LINE) |->
    o_bus.active_lane == `BLS_LANES_ALL)
    else $error("long or line cycle without all lanes");
  a_lock_end: assert property (o_bus.valid &&
    o_bus.locked_sequence_end |-> o_bus.lock)
    else $error("lock end outside a locked cycle");
  a_ack_addr: assert property (o_bus.valid &&
    o_bus.transfer_type == `BLS_TT_ACK |->
    o_bus.transfer_size == `BLS_SIZ_BYTE &&
    (o_bus.address == `BLS_ADDR_INT_ACK ||
    o_bus.address == `BLS_ADDR_BKPT_ACK))
    else $error("acknowledge cycle with wrong address or size");
endmodule : bls_chk

bind bls_bus_lane_steer_and_split bls_chk u_chk (
  .i_clock(i_clock),
  .i_sys_rst(i_sys_rst),
  .i_req_valid(i_req_valid),
  .i_req(i_req),
  .i_cycle_done(i_cycle_done),
  .i_burst_inhibit(i_burst_inhibit),
  .i_bus_rdata(i_bus_rdata),
  .o_req_ready(o_req_ready),
  .o_bus(o_bus),
  .o_rsp(o_rsp)
);

/* File: bls_slave.sv */
/*
  Behavioural 32-bit slave on the far side of the bus: 256 bytes,
  programmable wait states, optional burst inhibit on lines.
  Assumes the bench holds i_wait and i_bi steady during a cycle.
*/
`timescale 1ns/1ps
`include "bls_map.svh"

module bls_slave (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire bls_pkg::bls_bus_t i_bus,
  input wire logic [1:0] i_wait,
  input wire logic i_bi,
  output logic o_done,
  output logic o_bi,
  output logic [31:0] o_rdata
);
  logic [7:0] mem [0:255];
  logic [1:0] cnt;
  logic [31:0] fill;
  int k;

  // Known fill pattern so the bench can predict every byte
  initial
  begin
    for (k = 0; k < 256; k++)
      mem[k] = k[7:0] ^ 8'hA5;
    o_done = 1'b0;
    o_bi = 1'b0;
    o_rdata = 32'h0;
    fill = 32'h0F0F0F0F;
    cnt = 2'h0;
  end

  // Full-width 32-bit port, no narrowing; unused lanes toggle junk
  always @(posedge i_clock)
  begin
    fill <= ~fill;
    o_done <= 1'b0;
    o_bi <= 1'b0;
    o_rdata <= fill;
    if (i_sys_rst)
      cnt <= 2'h0;
    else if (i_bus.valid && !o_done)
    begin
      if (cnt == i_wait)
      begin
        cnt <= 2'h0;
        o_done <= 1'b1;
        o_bi <= i_bi && (i_bus.transfer_size == `BLS_SIZ_LINE);
        for (k = 0; k < 4; k++)
          if (i_bus.active_lane[3 - k])
          begin
            o_rdata[31 - 8 * k -: 8] <= mem[{i_bus.address[7:2], k[1:0]}];
            if (i_bus.write)
              mem[{i_bus.address[7:2], k[1:0]}] <= i_bus.wdata[31-8*k -: 8];
          end
      end
      else
        cnt <= cnt + 2'h1;
    end
  end
endmodule : bls_slave

/* File: tb_top.sv */
/*
  Self-checking bench for the bus lane steer and split block.
  Assumes the slave model and the bound checker are compiled too.
*/
`timescale 1ns/1ps
`include "bls_map.svh"

module tb_top;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_req_valid = 1'b0;
  bls_pkg::bls_req_t i_req = '0;
  logic i_cycle_done, i_burst_inhibit, o_req_ready;
  logic [31:0] i_bus_rdata;
  bls_pkg::bls_bus_t o_bus;
  bls_pkg::bls_rsp_t o_rsp;
  logic [1:0] wait_cyc = 2'h0;
  logic bi_mode = 1'b0;
  int mismatches = 0;
  int cmp_count = 0;
  bls_pkg::bls_bus_t bq[$];
  bls_pkg::bls_rsp_t rq[$];

  bls_bus_lane_steer_and_split u_dut (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_req_valid(i_req_valid), .i_req(i_req),
    .i_cycle_done(i_cycle_done), .i_burst_inhibit(i_burst_inhibit),
    .i_bus_rdata(i_bus_rdata), .o_req_ready(o_req_ready),
    .o_bus(o_bus), .o_rsp(o_rsp));
  bls_slave u_slave (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_bus(o_bus), .i_wait(wait_cyc), .i_bi(bi_mode),
    .o_done(i_cycle_done), .o_bi(i_burst_inhibit), .o_rdata(i_bus_rdata));

  initial
    forever #2.5 i_clock = ~i_clock;

  // Mid-cycle log of finished bus cycles and responses, race free
  always @(negedge i_clock)
  begin
    if (o_bus.valid === 1'b1 && i_cycle_done === 1'b1)
      bq.push_back(o_bus);
    if (o_rsp.valid === 1'b1)
      rq.push_back(o_rsp);
  end

  task end_sim;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Right-justified big-endian bytes from the slave's fill pattern
  function automatic logic [31:0] expd(input logic [7:0] a, input int n);
    logic [31:0] d;
    d = 32'h0;
    for (int i = 0; i < n; i++)
      d = {d[23:0], (a + i[7:0]) ^ 8'hA5};
    return d;
  endfunction : expd

  function automatic bls_pkg::bls_req_t mkreq(input bls_pkg::bls_class_t c,
    input logic [31:0] a, input logic [1:0] s);
    mkreq = '0;
    mkreq.acc_class = c;
    mkreq.address = a;
    mkreq.transfer_size = s;
    mkreq.transfer_modifier = 3'h1;
  endfunction : mkreq

  // One request, waits bounded until the block is idle again
  task automatic run(input bls_pkg::bls_req_t r);
    int t;
    bq.delete();
    rq.delete();
    @(posedge i_clock);
    i_req <= r;
    i_req_valid <= 1'b1;
    @(posedge i_clock);
    i_req_valid <= 1'b0;
    #1;
    t = 0;
    while (o_req_ready !== 1'b1 && t < 300)
    begin
      @(posedge i_clock);
      #1;
      t++;
    end
    if (t >= 300)
    begin
      mismatches++;
      end_sim();
    end
    // Let the monitor log the final response before anyone reads it
    @(negedge i_clock);
    #1;
  endtask : run

  task automatic s_counts;
    logic [1:0] sz [3] = '{`BLS_SIZ_BYTE, `BLS_SIZ_WORD, `BLS_SIZ_LONG};
    int nc [3][4] = '{'{1, 1, 1, 1}, '{1, 2, 1, 2}, '{1, 3, 2, 3}};
    for (int s = 0; s < 3; s++)
      for (int o = 0; o < 4; o++)
      begin
        wait_cyc <= o[1:0];
        run(mkreq(bls_pkg::BLS_NORMAL, 32'h10 + o, sz[s]));
        chk("cycles", nc[s][o], bq.size());
        chk("first addr", 32'h10 + o, bq[0].address);
        chk("rdata", expd(8'h10 + o, 1 << s), rq[0].rdata);
      end
  endtask : s_counts

  task automatic s_split_lock;
    bls_pkg::bls_req_t r;
    logic [1:0] es [3] = '{`BLS_SIZ_BYTE, `BLS_SIZ_WORD, `BLS_SIZ_BYTE};
    logic [31:0] ea [3] = '{32'h51, 32'h52, 32'h54};
    r = mkreq(bls_pkg::BLS_NORMAL, 32'h51, `BLS_SIZ_LONG);
    r.write = 1'b1;
    r.wdata = 32'hC3D2E1F0;
    r.lock = 1'b1;
    r.lock_end = 1'b1;
    wait_cyc <= 2'h1;
    run(r);
    for (int i = 0; i < 3; i++)
    begin
      chk("split size", es[i], bq[i].transfer_size);
      chk("split addr", ea[i], bq[i].address);
      chk("lock", 1, bq[i].lock);
      chk("lock end", i == 2, bq[i].locked_sequence_end);
    end
    chk("lane1 wdata", 8'hC3, bq[0].wdata[23:16]);
    run(mkreq(bls_pkg::BLS_NORMAL, 32'h51, `BLS_SIZ_LONG));
    chk("read back", 32'hC3D2E1F0, rq[0].rdata);
  endtask : s_split_lock

  task automatic s_cache_fetch;
    bls_pkg::bls_req_t r;
    r = mkreq(bls_pkg::BLS_NORMAL, 32'h31, `BLS_SIZ_LONG);
    r.cachable = 1'b1;
    run(r);
    chk("cachable cycles", 1, bq.size());
    r = mkreq(bls_pkg::BLS_NORMAL, 32'h33, `BLS_SIZ_WORD);
    r.fetch = 1'b1;
    run(r);
    chk("odd fetch error", 1, rq[0].addr_error);
    chk("odd fetch cycles", 0, bq.size());
    r.address = 32'h32;
    run(r);
    chk("even fetch error", 0, rq[0].addr_error);
  endtask : s_cache_fetch

  task automatic s_classes;
    bls_pkg::bls_req_t r;
    logic [1:0] tt [7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    for (int c = 0; c < 7; c++)
    begin
      r = mkreq(bls_pkg::bls_class_t'(c[2:0]), 32'h40,
        c == 3 ? `BLS_SIZ_LINE : `BLS_SIZ_LONG);
      r.write = (c == 0);
      r.cache_mode_field = 1'b1;
      r.user_page_bits = 2'h2;
      r.cache_line_entry = 2'h3;
      run(r);
      chk("type", tt[c], bq[0].transfer_type);
      chk("tm", (c == 0 || c == 6) ? 0 : 1, bq[0].transfer_modifier);
      chk("addr", c == 5 ? 32'hFFFFFFFF : c == 6 ? 0 : 32'h40,
        bq[0].address);
      chk("upa", (c == 1 || c == 3) ? 2 : 0, bq[0].user_page_attribute);
      chk("cio", c == 1 || c == 3 || c == 4, bq[0].cache_inhibit_out);
      if (c != 1 && c != 3)
        chk("line entry", c == 0 ? 3 : 0, bq[0].cache_line_entry);
    end
  endtask : s_classes

  task automatic s_line_inhibit;
    logic [7:0] a;
    bi_mode <= 1'b1;
    wait_cyc <= 2'h0;
    run(mkreq(bls_pkg::BLS_NORMAL, 32'h2A, `BLS_SIZ_LINE));
    bi_mode <= 1'b0;
    chk("line cycles", 4, bq.size());
    chk("line rsps", 4, rq.size());
    for (int k = 0; k < 4; k++)
    begin
      a = {4'h2, 2'(2 + k), 2'h2};
      chk("line addr", {24'h0, a}, bq[k].address);
      chk("line data", expd({a[7:2], 2'h0}, 4), rq[k].rdata);
    end
  endtask : s_line_inhibit

  initial
  begin
    repeat (8) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    #1;
    chk("ready after reset", 1, o_req_ready);
    chk("bus after reset", 0, o_bus.valid);
    s_counts();
    s_split_lock();
    s_cache_fetch();
    s_classes();
    s_line_inhibit();
    end_sim();
  end
endmodule : tb_top
